// File: src/olw_pkg.sv
/*
  Constants, addresses and field positions for the option latches and watchdog.
  Assumes one 10 MHz system clock, with crystal-clock events arriving as single-cycle ticks.
*/
// Notes on behaviour
// RULE_01: Each option latch takes one write per reset; both always readable.
// RULE_02: Low-voltage range bit writable once per power-on; only power-on clears it.
// RULE_03: CAN enable bit hands the controller two pins; only power-on clears it.
// RULE_04: Timebase prescale bit inserts a divide-by-128 stage; otherwise bypassed.
// RULE_05: Oscillator-in-sleep bit keeps the oscillator running during stop mode.
// RULE_06: Serial baud source: bus clock when set, crystal clock when clear.
// RULE_07: Watchdog rate bit picks 2^13-2^4 or 2^18-2^4 cycles; reset clears it.
// RULE_08: Keep-in-sleep bit keeps the monitor on in stop unless powered off.
// RULE_09: Reset-off bit blocks monitor resets; power-off bit powers the monitor down.
// RULE_10: Range bit selects 5-volt trip mode when set, 3-volt when clear.
// RULE_11: Fast-wake bit gives 32-cycle stop exit, otherwise 4096 cycles.
// RULE_12: Stop exit caused by low-voltage reset always takes the long delay.
// RULE_13: Stop instruction is illegal unless the sleep-allow bit is set.
// RULE_14: Watchdog disable bit switches the watchdog off, followed live.
// RULE_15: Watchdog is a 12-bit prescaler feeding a 6-bit counter; overflow resets.
// RULE_16: Service write clears counter and prescaler stages 12 to 5 only.
// RULE_17: Reading the service location returns the reset vector low byte.
// RULE_18: Watchdog reset pulls reset pin low 32 cycles and sets cause flag.
// RULE_19: Executing the stop instruction clears the watchdog prescaler.
// RULE_20: Power-on logic clears the prescaler 4096 crystal cycles after power-up.
// RULE_21: Any internal reset clears prescaler and counter.
// RULE_22: Reset vector fetch clears the watchdog prescaler.
// RULE_23: Option bits reset to 0, baud source to 1, power-on bits kept.

package olw_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [15:0] OLW_ADDR_LATCH_TWO = 16'h001E;
  localparam logic [15:0] OLW_ADDR_LATCH_ONE = 16'h001F;
  localparam logic [15:0] OLW_ADDR_STATUS    = 16'h0020;
  localparam logic [15:0] OLW_ADDR_COUNT     = 16'h0021;
  localparam logic [15:0] OLW_ADDR_SERVICE   = 16'hFFFF;
  localparam logic [15:0] OLW_ADDR_VECTOR    = 16'hFFFE;

  // ****************************************
  // Option latch one fields
  // ****************************************
  localparam int OLW_B1_RATE  = 7;
  localparam int OLW_B1_KEEP  = 6;
  localparam int OLW_B1_LRST  = 5;
  localparam int OLW_B1_LPWR  = 4;
  localparam int OLW_B1_RANGE = 3;
  localparam int OLW_B1_FAST  = 2;
  localparam int OLW_B1_STOP  = 1;
  localparam int OLW_B1_WDIS  = 0;

  // ****************************************
  // Option latch two fields
  // ****************************************
  localparam int OLW_B2_CAN  = 3;
  localparam int OLW_B2_TB   = 2;
  localparam int OLW_B2_OSC  = 1;
  localparam int OLW_B2_BAUD = 0;
  localparam logic [7:0] OLW_L2_MASK  = 8'h0F;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] OLW_L1_RST = 8'h00;
  localparam logic [7:0] OLW_L2_RST = 8'h01;

  // ****************************************
  // Watchdog and delay counts
  // ****************************************
  localparam int          OLW_PRE_W      = 12;
  localparam int          OLW_CNT_W      = 6;
  localparam int          OLW_SVC_LO     = 4;
  localparam logic [17:0] OLW_WD_LONG    = 18'h3FFF0;
  localparam logic [17:0] OLW_WD_SHORT   = 18'h01FF0;
  localparam int          OLW_DLY_W      = 13;
  localparam logic [12:0] OLW_WAKE_SHORT = 13'h0020;
  localparam logic [12:0] OLW_WAKE_LONG  = 13'h1000;
  localparam logic [12:0] OLW_STRETCH    = 13'h0020;
  localparam logic [12:0] OLW_POR_WAIT   = 13'h1000;
  localparam logic [6:0]  OLW_TB_LAST    = 7'h7F;

  function automatic logic [17:0] olw_wdog_limit(input logic rate);
    return rate ? OLW_WD_SHORT : OLW_WD_LONG;
  endfunction : olw_wdog_limit

endpackage : olw_pkg

// File: src/olw_delay.sv
/*
  Tick-counted delay: loads a length, counts crystal ticks, pulses done.
  Assumes start and tick are synchronous single-cycle events.
*/
`timescale 1ns/1ns
module olw_delay #(
  parameter int W = 13
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Control
  input  wire logic         start,
  input  wire logic [W-1:0] len,
  input  wire logic         tick,
  // Status
  output logic              busy,
  output logic              done
);

  if (W < 2) begin : g_chk
    $error("olw_delay width too small");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         done;
  } olw_dly_t;

  olw_dly_t st_reg;
  olw_dly_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (start) begin
      st_next.cnt  = len;
      st_next.busy = 1'b1;
    end else if (st_reg.busy && tick) begin
      if (st_reg.cnt <= W'(1)) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
  assign done = st_reg.done;

endmodule : olw_delay

// File: src/olw_wdog.sv
/*
  Watchdog core: prescaler feeding a counter, overflow pulse and clears.
  Assumes tick marks one crystal clock period; clears are single-cycle.
*/
`timescale 1ns/1ns
module olw_wdog #(
  parameter int PRE_W = 12,
  parameter int CNT_W = 6
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Control
  input  wire logic             tick,
  input  wire logic             enable,
  input  wire logic             rate,
  input  wire logic             clr_svc,
  input  wire logic             clr_pre,
  input  wire logic             clr_all,
  // Status
  output logic                  fire,
  output logic [PRE_W-1:0]      pre,
  output logic [CNT_W-1:0]      cnt
);

  if (PRE_W + CNT_W != 18 || PRE_W <= olw_pkg::OLW_SVC_LO) begin : g_chk
    $error("olw_wdog widths must total 18 bits");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [PRE_W-1:0] pre;
    logic             fire;
  } olw_wd_t;

  olw_wd_t st_reg;
  olw_wd_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.fire = 1'b0;
    if (enable && tick) begin                                       // see RULE_14
      {st_next.cnt, st_next.pre} = 18'({st_reg.cnt, st_reg.pre} + 18'h00001);  // see RULE_15
      st_next.fire = ({st_reg.cnt, st_reg.pre} == olw_pkg::olw_wdog_limit(rate) - 18'h00001);  // see RULE_07
    end
    if (clr_svc) begin
      st_next.cnt  = '0;                                            // see RULE_16
      st_next.pre[PRE_W-1:olw_pkg::OLW_SVC_LO] = '0;
      st_next.fire = 1'b0;
    end
    if (clr_pre) begin
      st_next.pre = '0;                                             // see RULE_19
    end
    if (clr_all) begin
      st_next = '0;                                                 // see RULE_21
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fire = st_reg.fire;
  assign pre  = st_reg.pre;
  assign cnt  = st_reg.cnt;

  property p_svc;
    @(posedge clk) disable iff (sys_rst)
      clr_svc |=> (cnt == '0) && (pre[PRE_W-1:olw_pkg::OLW_SVC_LO] == '0) && !fire;
  endproperty
  a_svc: assert property (p_svc) else $error("service did not clear watchdog"); // see RULE_16

  property p_pre_clr;
    @(posedge clk) disable iff (sys_rst)
      clr_pre |=> (pre == '0);
  endproperty
  a_pre_clr: assert property (p_pre_clr) else $error("prescaler not cleared"); // see RULE_22

  property p_all_clr;
    @(posedge clk) disable iff (sys_rst)
      clr_all |=> (pre == '0) && (cnt == '0) && !fire;
  endproperty
  a_all_clr: assert property (p_all_clr) else $error("internal reset left watchdog"); // see RULE_21

endmodule : olw_wdog

// File: src/olw_top.sv
/*
  Option latches with the watchdog, stop-mode and option-driven outputs.
  Assumes a byte register port with read data one cycle after the strobe,
  crystal-clock ticks as single-cycle pulses, and internal resets as pulses.
*/
// Chosen here: strobed register access.
`timescale 1ns/1ns
module olw_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        int_rst,
  // Register port
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rd_data,
  // Core events
  input  wire logic [7:0]  reset_vec_lo,
  input  wire logic        vec_fetch,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        stop_exec,
  input  wire logic        stop_exit,
  input  wire logic        stop_exit_lowv,
  // Clock sources
  input  wire logic        xtal_tick,
  input  wire logic        tb_src_tick,
  // Watchdog results
  output logic             wdog_chip_rst,
  output logic             rst_pin_drive_low,
  output logic             wdog_cause,
  // Stop mode
  output logic             stop_enter,
  output logic             illegal_op,
  output logic             wake_done,
  output logic             osc_halt,
  // Low-voltage monitor control
  output logic             lowv_run,
  output logic             lowv_reset_block,
  output logic             lowv_power_down,
  output logic             lowv_5v_mode,
  // Peripheral options
  output logic             can_enable,
  output logic      [1:0]  can_pin_own,
  output logic             tb_tick,
  output logic             serial_tick
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]  l1;
    logic [7:0]  l2;
    logic        one_done;
    logic        two_done;
    logic        range_done;
    logic        cause;
    logic        in_stop;
    logic        stop_enter;
    logic        illegal_op;
    logic        osc_halt;
    logic        lowv_run;
    logic [6:0]  tb_div;
    logic        tb_tick;
    logic        serial_tick;
    logic [12:0] por_cnt;
    logic        por_done;
    logic        por_clr;
    logic [7:0]  rd_data;
  } olw_main_t;

  localparam olw_main_t ST_RST = '{
    l1:       olw_pkg::OLW_L1_RST,
    l2:       olw_pkg::OLW_L2_RST,
    lowv_run: 1'b1,
    default:  '0
  };

  olw_main_t st_reg;
  olw_main_t st_next;

  // ****************************************
  // Sub-block wiring
  // ****************************************
  logic                          wd_fire;
  logic [olw_pkg::OLW_PRE_W-1:0] wd_pre;
  logic [olw_pkg::OLW_CNT_W-1:0] wd_cnt;
  logic                          irst;
  logic                          svc_wr;
  logic                          stop_ok;
  logic                          vec_clr;
  logic                          rec_start;
  logic [olw_pkg::OLW_DLY_W-1:0] rec_len;
  logic                          rec_busy;
  logic                          rec_done;
  logic                          str_busy;

  assign irst    = int_rst | wd_fire;
  assign svc_wr  = wr_stb && (addr == olw_pkg::OLW_ADDR_SERVICE);
  assign stop_ok = stop_exec && st_reg.l1[olw_pkg::OLW_B1_STOP];
  assign vec_clr = vec_fetch && (fetch_addr[15:1] == olw_pkg::OLW_ADDR_VECTOR[15:1]);  // see RULE_22

  // Low-voltage exit always takes the long recovery
  assign rec_start = stop_exit && st_reg.in_stop;
  assign rec_len   = (stop_exit_lowv || !st_reg.l1[olw_pkg::OLW_B1_FAST]) ?  // see RULE_12
                     olw_pkg::OLW_WAKE_LONG : olw_pkg::OLW_WAKE_SHORT;      // see RULE_11

  olw_wdog #(
    .PRE_W (olw_pkg::OLW_PRE_W),
    .CNT_W (olw_pkg::OLW_CNT_W)
  ) u_wdog (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (xtal_tick),
    .enable  (!st_reg.l1[olw_pkg::OLW_B1_WDIS]),
    .rate    (st_reg.l1[olw_pkg::OLW_B1_RATE]),
    .clr_svc (svc_wr),
    .clr_pre (stop_ok | st_reg.por_clr | vec_clr),
    .clr_all (irst),
    .fire    (wd_fire),
    .pre     (wd_pre),
    .cnt     (wd_cnt)
  );

  // Reset pin stretch after a watchdog overflow
  olw_delay #(
    .W (olw_pkg::OLW_DLY_W)
  ) u_stretch (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (wd_fire),
    .len     (olw_pkg::OLW_STRETCH),
    .tick    (xtal_tick),
    .busy    (str_busy),
    .done    ()
  );

  // Stop-mode recovery delay
  olw_delay #(
    .W (olw_pkg::OLW_DLY_W)
  ) u_recover (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (rec_start),
    .len     (rec_len),
    .tick    (xtal_tick),
    .busy    (rec_busy),
    .done    (rec_done)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next            = st_reg;
    st_next.stop_enter = 1'b0;
    st_next.illegal_op = 1'b0;
    st_next.por_clr    = 1'b0;
    st_next.rd_data    = '0;

    // Option writes, one per reset
    if (irst) begin
      st_next.one_done = 1'b0;                                      // see RULE_01
      st_next.two_done = 1'b0;
      st_next.l1       = olw_pkg::OLW_L1_RST;                       // see RULE_23
      st_next.l1[olw_pkg::OLW_B1_RANGE] = st_reg.l1[olw_pkg::OLW_B1_RANGE];  // see RULE_02
      st_next.l2       = olw_pkg::OLW_L2_RST;
      st_next.l2[olw_pkg::OLW_B2_CAN]   = st_reg.l2[olw_pkg::OLW_B2_CAN];    // see RULE_03
      st_next.in_stop  = 1'b0;
    end else if (wr_stb) begin
      if (addr == olw_pkg::OLW_ADDR_LATCH_ONE && !st_reg.one_done) begin
        st_next.one_done = 1'b1;                                    // see RULE_01
        st_next.l1       = wr_data;
        if (st_reg.range_done) begin
          st_next.l1[olw_pkg::OLW_B1_RANGE] = st_reg.l1[olw_pkg::OLW_B1_RANGE];  // see RULE_02
        end
        st_next.range_done = 1'b1;
      end
      if (addr == olw_pkg::OLW_ADDR_LATCH_TWO && !st_reg.two_done) begin
        st_next.two_done = 1'b1;                                    // see RULE_01
        st_next.l2       = wr_data & olw_pkg::OLW_L2_MASK;
      end
    end

    // Cause flag: a fresh watchdog event wins over a clear
    if (int_rst) begin
      st_next.cause = 1'b0;
    end
    if (wd_fire) begin
      st_next.cause = 1'b1;                                         // see RULE_18
    end

    // Stop instruction
    if (stop_exec && !irst) begin
      if (st_reg.l1[olw_pkg::OLW_B1_STOP]) begin
        st_next.stop_enter = 1'b1;                                  // see RULE_13
        st_next.in_stop    = 1'b1;
      end else begin
        st_next.illegal_op = 1'b1;                                  // see RULE_13
      end
    end
    if (rec_start) begin
      st_next.in_stop = 1'b0;
    end

    // Option-driven levels, registered
    st_next.osc_halt = st_next.in_stop && !st_next.l2[olw_pkg::OLW_B2_OSC];  // see RULE_05
    st_next.lowv_run = !st_next.l1[olw_pkg::OLW_B1_LPWR] &&                   // see RULE_09
                       (!st_next.in_stop || st_next.l1[olw_pkg::OLW_B1_KEEP]);  // see RULE_08

    // Timebase path with optional divide-by-128
    st_next.tb_tick = 1'b0;
    if (st_reg.l2[olw_pkg::OLW_B2_TB]) begin
      if (tb_src_tick) begin
        st_next.tb_div  = 7'(st_reg.tb_div + 7'h01);                // see RULE_04
        st_next.tb_tick = (st_reg.tb_div == olw_pkg::OLW_TB_LAST);
      end
    end else begin
      st_next.tb_div  = '0;
      st_next.tb_tick = tb_src_tick;                                // see RULE_04
    end

    // Serial clock source
    st_next.serial_tick = st_reg.l2[olw_pkg::OLW_B2_BAUD] ? 1'b1 : xtal_tick;  // see RULE_06

    // One-shot prescaler clear after power-up
    if (!st_reg.por_done && xtal_tick) begin
      st_next.por_cnt = 13'(st_reg.por_cnt + 13'h0001);
      if (st_next.por_cnt == olw_pkg::OLW_POR_WAIT) begin
        st_next.por_done = 1'b1;
        st_next.por_clr  = 1'b1;                                    // see RULE_20
      end
    end

    // Read data, one cycle after the strobe
    if (rd_stb) begin
      unique case (addr)
        olw_pkg::OLW_ADDR_LATCH_ONE: begin
          st_next.rd_data = st_reg.l1;
        end
        olw_pkg::OLW_ADDR_LATCH_TWO: begin
          st_next.rd_data = st_reg.l2;
        end
        olw_pkg::OLW_ADDR_SERVICE: begin
          st_next.rd_data = reset_vec_lo;                           // see RULE_17
        end
        olw_pkg::OLW_ADDR_STATUS: begin
          st_next.rd_data = {3'h0, rec_busy, st_reg.in_stop, st_reg.two_done,
                             st_reg.one_done, st_reg.cause};
        end
        olw_pkg::OLW_ADDR_COUNT: begin
          st_next.rd_data = {2'h0, wd_cnt};
        end
        default: begin
          st_next.rd_data = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rd_data           = st_reg.rd_data;
  assign wdog_chip_rst     = wd_fire;                                // see RULE_15
  assign rst_pin_drive_low = str_busy;
  assign wdog_cause        = st_reg.cause;
  assign stop_enter        = st_reg.stop_enter;
  assign illegal_op        = st_reg.illegal_op;
  assign wake_done         = rec_done;
  assign osc_halt          = st_reg.osc_halt;
  assign lowv_run          = st_reg.lowv_run;
  assign lowv_reset_block  = st_reg.l1[olw_pkg::OLW_B1_LRST];        // see RULE_09
  assign lowv_power_down   = st_reg.l1[olw_pkg::OLW_B1_LPWR];
  assign lowv_5v_mode      = st_reg.l1[olw_pkg::OLW_B1_RANGE];       // see RULE_10
  assign can_enable        = st_reg.l2[olw_pkg::OLW_B2_CAN];         // see RULE_03
  assign can_pin_own       = {2{st_reg.l2[olw_pkg::OLW_B2_CAN]}};
  assign tb_tick           = st_reg.tb_tick;
  assign serial_tick       = st_reg.serial_tick;

  // ****************************************
  // Checks
  // ****************************************
  property p_once;
    @(posedge clk) disable iff (sys_rst)
      (wr_stb && addr == olw_pkg::OLW_ADDR_LATCH_ONE && st_reg.one_done && !irst) |=> $stable(st_reg.l1);
  endproperty
  a_once: assert property (p_once) else $error("option latch rewritten"); // see RULE_01

  property p_range_keep;
    @(posedge clk) disable iff (sys_rst)
      irst |=> $stable(lowv_5v_mode) && $stable(can_enable);
  endproperty
  a_range_keep: assert property (p_range_keep) else $error("power-on bit lost on reset"); // see RULE_02

  property p_rate_clr;
    @(posedge clk) disable iff (sys_rst)
      irst |=> !st_reg.l1[olw_pkg::OLW_B1_RATE] && !st_reg.one_done && st_reg.l2[olw_pkg::OLW_B2_BAUD];
  endproperty
  a_rate_clr: assert property (p_rate_clr) else $error("reset values wrong"); // see RULE_07

  property p_illegal;
    @(posedge clk) disable iff (sys_rst)
      (stop_exec && !irst && !st_reg.l1[olw_pkg::OLW_B1_STOP]) |=> illegal_op && !stop_enter;
  endproperty
  a_illegal: assert property (p_illegal) else $error("stop not refused"); // see RULE_13

  property p_disable;
    @(posedge clk) disable iff (sys_rst)
      st_reg.l1[olw_pkg::OLW_B1_WDIS] |=> !wdog_chip_rst;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled watchdog fired"); // see RULE_14

  property p_stretch;
    @(posedge clk) disable iff (sys_rst)
      wd_fire |=> rst_pin_drive_low [*8] ##0 wdog_cause;
  endproperty
  a_stretch: assert property (p_stretch) else $error("reset pin not held low"); // see RULE_18

  property p_tb_bypass;
    @(posedge clk) disable iff (sys_rst)
      (!st_reg.l2[olw_pkg::OLW_B2_TB] && tb_src_tick) |=> tb_tick;
  endproperty
  a_tb_bypass: assert property (p_tb_bypass) else $error("timebase bypass lost tick"); // see RULE_04

  property p_tb_div;
    @(posedge clk) disable iff (sys_rst)
      (st_reg.l2[olw_pkg::OLW_B2_TB] && st_reg.tb_div != olw_pkg::OLW_TB_LAST) |=> !tb_tick;
  endproperty
  a_tb_div: assert property (p_tb_div) else $error("timebase divider early tick"); // see RULE_04

  property p_baud;
    @(posedge clk) disable iff (sys_rst)
      st_reg.l2[olw_pkg::OLW_B2_BAUD] |=> serial_tick;
  endproperty
  a_baud: assert property (p_baud) else $error("serial clock not bus clock"); // see RULE_06

  property p_lowv_stop;
    @(posedge clk) disable iff (sys_rst)
      (st_reg.in_stop && st_reg.l1[olw_pkg::OLW_B1_LPWR]) |-> !lowv_run;
  endproperty
  a_lowv_stop: assert property (p_lowv_stop) else $error("monitor on while powered off"); // see RULE_08

  property p_vec_read;
    @(posedge clk) disable iff (sys_rst)
      (rd_stb && addr == olw_pkg::OLW_ADDR_SERVICE && !irst) |=>
        (rd_data == $past(reset_vec_lo)) && (wd_cnt >= $past(wd_cnt));
  endproperty
  a_vec_read: assert property (p_vec_read) else $error("service read wrong"); // see RULE_17

endmodule : olw_top

// File: verification/olw_testbench.sv
/*
  Self-checking bench for olw_top: option latches, stop handling and watchdog.
  Assumes the crystal tick runs every clock cycle and the design holds its own assertions.
*/
`timescale 1ns/1ns
module testbench;
  logic        clk, sys_rst, int_rst, wr_stb, rd_stb, vec_fetch, stop_exec, stop_exit, stop_exit_lowv;
  logic        xtal_tick, tb_src_tick, wdog_chip_rst, rst_pin_drive_low, wdog_cause, stop_enter, illegal_op;
  logic        wake_done, osc_halt, lowv_run, lowv_reset_block, lowv_power_down, lowv_5v_mode, can_enable;
  logic        tb_tick, serial_tick;
  logic [1:0]  can_pin_own;
  logic [7:0]  wr_data, rd_data, reset_vec_lo;
  logic [15:0] addr, fetch_addr;
  int          fails, cmp_count, cyc, n;

  olw_top olw_top_inst (
    .clk(clk), .sys_rst(sys_rst), .int_rst(int_rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .reset_vec_lo(reset_vec_lo), .vec_fetch(vec_fetch),
    .fetch_addr(fetch_addr), .stop_exec(stop_exec), .stop_exit(stop_exit), .stop_exit_lowv(stop_exit_lowv),
    .xtal_tick(xtal_tick), .tb_src_tick(tb_src_tick), .wdog_chip_rst(wdog_chip_rst),
    .rst_pin_drive_low(rst_pin_drive_low), .wdog_cause(wdog_cause), .stop_enter(stop_enter),
    .illegal_op(illegal_op), .wake_done(wake_done), .osc_halt(osc_halt), .lowv_run(lowv_run),
    .lowv_reset_block(lowv_reset_block), .lowv_power_down(lowv_power_down), .lowv_5v_mode(lowv_5v_mode),
    .can_enable(can_enable), .can_pin_own(can_pin_own), .tb_tick(tb_tick), .serial_tick(serial_tick)
  );

  always #50 clk = ~clk;

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rd_data, exp);
  endtask : rd

  task automatic stop_pulse();
    @(posedge clk) stop_exec <= 1'b1;
    @(posedge clk) stop_exec <= 1'b0;
    #1;
  endtask : stop_pulse

  task automatic exit_stop(input logic lowv);
    @(posedge clk);
    stop_exit      <= 1'b1;
    stop_exit_lowv <= lowv;
    @(posedge clk);
    stop_exit      <= 1'b0;
    stop_exit_lowv <= 1'b0;
  endtask : exit_stop

  // Cycles until the chosen pulse: 0 watchdog reset, 1 wake done, 2 timebase tick
  task automatic count_hi(input logic [1:0] sel, input int lim);
    n = 0;
    while ((sel == 2'd0 ? wdog_chip_rst : sel == 2'd1 ? wake_done : tb_tick) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
      #1;
    end
  endtask : count_hi

  task automatic summarize();
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      summarize();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {clk, int_rst, wr_stb, rd_stb, vec_fetch, stop_exec, stop_exit, stop_exit_lowv, tb_src_tick} = '0;
    {addr, fetch_addr, wr_data, fails, cmp_count} = '0;
    xtal_tick = 1'b1;
    reset_vec_lo = 8'hA5;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(16'h001F, 8'h00);
    rd(16'h001E, 8'h01);
    chk(serial_tick, 1'b1);
    wr(16'h001F, 8'h09);
    wr(16'h001F, 8'hFF);
    rd(16'h001F, 8'h09);
    chk(lowv_5v_mode, 1'b1);
    wr(16'h001E, 8'hFE);
    rd(16'h001E, 8'h0E);
    chk({can_enable, can_pin_own}, 3'b111);
    @(posedge clk) tb_src_tick <= 1'b1;
    count_hi(2'd2, 300);
    chk(n == 128, 1'b1);
    repeat (4200) @(posedge clk);
    rd(16'h0021, 8'h00);
    stop_pulse();
    chk(illegal_op, 1'b1);
    @(posedge clk) int_rst <= 1'b1;
    @(posedge clk) int_rst <= 1'b0;
    rd(16'h001F, 8'h08);
    rd(16'h001E, 8'h09);
    chk(tb_tick, 1'b1);
    wr(16'h001F, 8'h82);
    rd(16'h001F, 8'h8A);
    stop_pulse();
    chk({stop_enter, osc_halt}, 2'b11);
    chk(lowv_run, 1'b0);
    exit_stop(1'b0);
    @(posedge clk) #1 chk(osc_halt, 1'b0);
    rd(16'hFFFF, 8'hA5);
    @(posedge clk) vec_fetch <= 1'b1;
    fetch_addr <= 16'hFFFE;
    @(posedge clk) vec_fetch <= 1'b0;
    wr(16'hFFFF, 8'h00);
    count_hi(2'd0, 9000);
    // Vector fetch cleared the prescaler two ticks before the service write
    chk(n == 8174, 1'b1);
    @(posedge clk) #1 chk({rst_pin_drive_low, wdog_cause}, 2'b11);
    rd(16'h0021, 8'h00);
    rd(16'h001F, 8'h08);
    wr(16'h001F, 8'h66);
    rd(16'h001F, 8'h6E);
    chk({lowv_run, lowv_reset_block, lowv_power_down}, 3'b110);
    stop_pulse();
    chk(lowv_run, 1'b1);
    exit_stop(1'b0);
    count_hi(2'd1, 5000);
    chk(n == 32, 1'b1);
    @(posedge clk) int_rst <= 1'b1;
    @(posedge clk) int_rst <= 1'b0;
    wr(16'h001F, 8'h16);
    rd(16'h001F, 8'h1E);
    chk({lowv_run, lowv_power_down}, 2'b01);
    stop_pulse();
    exit_stop(1'b1);
    count_hi(2'd1, 5000);
    chk(n == 4096, 1'b1);
    summarize();
  end
endmodule : testbench
